// [rtl/ddr_io_datapath.sv]
// DDR read capture, DDR write output and clock phase generation datapath.
`timescale 1ns/1ps

module ddr_io_datapath
  import ddr_io_pkg::*;
#(
  parameter int unsigned QTR_CYCLES = QTR_CYC  // System cycles per quarter.
) (
  input  wire logic              clk_sys_in,    // System clock, 10 MHz.
  input  wire logic              rst_in,        // Synchronous reset, high.
  input  wire logic [DATA_W-1:0] dq_in,         // Data pins, read side.
  input  wire logic              cap_clk_in,    // Capture clock pin.
  input  wire logic [DLY_W-1:0]  cap_delay_in,  // Capture phase trim.
  input  wire wr_word_t          wr_word_in,    // Write word from core.
  input  wire logic              wr_en_in,      // Core write enable, high.
  output logic [DATA_W-1:0]      rd_hi_out,     // Read high half.
  output logic [DATA_W-1:0]      rd_lo_out,     // Read low half.
  output logic                   rd_valid_out,  // Read pair pulse.
  output logic [DATA_W-1:0]      dq_out,        // Data pins, drive value.
  output logic                   dq_oe_out,     // Data pins enable, high.
  output logic                   dm_out,        // Mask pin drive value.
  output logic                   dqs_out,       // Strobe drive value.
  output logic                   dqs_oe_out,    // Strobe enable, high.
  output logic                   mem_clk_out,   // Memory system clock.
  output logic                   wr_clk_out,    // Write clock, lags 90.
  output logic                   core_tick_out  // Core rate enable pulse.
);

  ////////////////////////////////////////////////////////////////////////////
  // Clock phase generation.
  ////////////////////////////////////////////////////////////////////////////

  logic [QCNT_W-1:0] qcnt_reg;    // Counts system cycles in a quarter.
  logic [QCNT_W-1:0] qcnt_next;   // Next quarter count.
  phase_t            phase_reg;   // Current memory clock quarter.
  phase_t            phase_next;  // Next memory clock quarter.
  logic              qtick;       // High in the last cycle of a quarter.

  localparam logic [QCNT_W-1:0] QCNT_LAST = QCNT_W'(QTR_CYCLES - 1);
  localparam logic [QCNT_W-1:0] QCNT_ZERO = '0;
  localparam logic [QCNT_W-1:0] QCNT_ONE  = QCNT_W'(1);

  // Divider: one enable pulse per quarter period; the phase steps on it.
  always_comb begin
    qtick      = (qcnt_reg == QCNT_LAST);
    qcnt_next  = qtick ? QCNT_ZERO : qcnt_reg + QCNT_ONE;
    phase_next = phase_reg;
    if (qtick) begin
      unique case (phase_reg)
        PH_Q0: phase_next = PH_Q1;
        PH_Q1: phase_next = PH_Q2;
        PH_Q2: phase_next = PH_Q3;
        PH_Q3: phase_next = PH_Q0;
      endcase
    end
  end

  // Phase registers.  Reset parks the phase at the end of the last low
  // quarter, which matches the low reset outputs, so the first clock high
  // after reset is a full half period and not a runt pulse.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      qcnt_reg  <= QCNT_LAST;
      phase_reg <= PH_Q3;
    end else begin
      qcnt_reg  <= qcnt_next;
      phase_reg <= phase_next;
    end
  end

  // Edge events of the generated clocks, seen one cycle ahead.
  logic sys_rise;  // System clock rises: entering Q0.
  logic sys_fall;  // System clock falls: entering Q2.
  logic wr_rise;   // Write clock rises: entering Q1.
  logic wr_fall;   // Write clock falls: entering Q3.

  always_comb begin
    sys_rise = qtick && (phase_next == PH_Q0);
    sys_fall = qtick && (phase_next == PH_Q2);
    wr_rise  = qtick && (phase_next == PH_Q1);
    wr_fall  = qtick && (phase_next == PH_Q3);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read capture.  The capture clock is not the strobe pin, so there is no
  // postamble window to gate off.
  ////////////////////////////////////////////////////////////////////////////

  logic [DATA_W-1:0] dq_meta_reg;   // First synchroniser stage, data.
  logic [DATA_W-1:0] dq_sync_reg;   // Second synchroniser stage, data.
  logic              cap_meta_reg;  // First synchroniser stage, clock.
  logic              cap_sync_reg;  // Second synchroniser stage, clock.
  logic              cap_prev_reg;  // Previous synchronised clock level.

  // Two-flop synchronisers for every pin the read path looks at.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      dq_meta_reg  <= DATA_RST;
      dq_sync_reg  <= DATA_RST;
      cap_meta_reg <= 1'b0;
      cap_sync_reg <= 1'b0;
      cap_prev_reg <= 1'b0;
    end else begin
      dq_meta_reg  <= dq_in;
      dq_sync_reg  <= dq_meta_reg;
      cap_meta_reg <= cap_clk_in;
      cap_sync_reg <= cap_meta_reg;
      cap_prev_reg <= cap_sync_reg;
    end
  end

  logic [DLY_W-1:0]  dly_reg,      dly_next;       // Phase trim countdown.
  logic              pend_r_reg,   pend_r_next;    // Rising sample pending.
  logic              pend_f_reg,   pend_f_next;    // Falling sample pending.
  logic [DATA_W-1:0] cap_a_reg,    cap_a_next;     // Rising-edge sample.
  logic [DATA_W-1:0] cap_b_reg,    cap_b_next;     // Falling-edge sample.
  logic [DATA_W-1:0] cap_c_reg,    cap_c_next;     // Aligned rising sample.
  logic              have_reg,     have_next;      // A full pair is held.
  rd_pair_t          sync_reg,     sync_next;      // Sync registers h and l.
  logic              rd_valid_reg, rd_valid_next;  // Pair handed over.
  logic              cap_rise;                     // Capture edge rose.
  logic              cap_fall;                     // Capture edge fell.
  logic              do_r;                         // Take rising sample now.
  logic              do_f;                         // Take falling sample now.

  localparam logic [DLY_W-1:0] DLY_ZERO = '0;
  localparam logic [DLY_W-1:0] DLY_ONE  = DLY_W'(1);

  // Each capture edge waits out the trim delay, then fires its sample.
  // The trim lets a calibration loop move the sampling point inside the
  // eye while traffic runs; a new edge restarts the wait.
  always_comb begin
    cap_rise      = cap_sync_reg && !cap_prev_reg;
    cap_fall      = !cap_sync_reg && cap_prev_reg;
    do_r          = pend_r_reg && (dly_reg == DLY_ZERO);
    do_f          = pend_f_reg && (dly_reg == DLY_ZERO);
    dly_next      = dly_reg;
    pend_r_next   = pend_r_reg && !do_r;
    pend_f_next   = pend_f_reg && !do_f;
    cap_a_next    = cap_a_reg;
    cap_b_next    = cap_b_reg;
    cap_c_next    = cap_c_reg;
    have_next     = have_reg;
    sync_next     = sync_reg;
    rd_valid_next = 1'b0;
    if ((pend_r_reg || pend_f_reg) && (dly_reg != DLY_ZERO)) begin
      dly_next = dly_reg - DLY_ONE;
    end
    if (do_r) begin
      cap_a_next = dq_sync_reg;
      if (have_reg) begin
        // Both halves are stable here, so they leave as one pair.
        sync_next.hi  = cap_c_reg;
        sync_next.lo  = cap_b_reg;
        rd_valid_next = 1'b1;
        have_next     = 1'b0;
      end
    end
    if (do_f) begin
      cap_b_next = dq_sync_reg;
      cap_c_next = cap_a_reg;
      have_next  = 1'b1;
    end
    if (cap_rise || cap_fall) begin
      dly_next = cap_delay_in;
    end
    if (cap_rise) begin
      pend_r_next = 1'b1;
    end
    if (cap_fall) begin
      pend_f_next = 1'b1;
    end
  end

  // Capture registers.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      dly_reg      <= DLY_ZERO;
      pend_r_reg   <= 1'b0;
      pend_f_reg   <= 1'b0;
      cap_a_reg    <= DATA_RST;
      cap_b_reg    <= DATA_RST;
      cap_c_reg    <= DATA_RST;
      have_reg     <= 1'b0;
      sync_reg     <= '0;
      rd_valid_reg <= 1'b0;
    end else begin
      dly_reg      <= dly_next;
      pend_r_reg   <= pend_r_next;
      pend_f_reg   <= pend_f_next;
      cap_a_reg    <= cap_a_next;
      cap_b_reg    <= cap_b_next;
      cap_c_reg    <= cap_c_next;
      have_reg     <= have_next;
      sync_reg     <= sync_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write output path.  Data and mask run on the write clock; the strobe
  // and its enable run on the system clock.
  ////////////////////////////////////////////////////////////////////////////

  wr_word_t          word_reg,    word_next;    // Low and high stream flops.
  logic [DATA_W-1:0] lo_fall_reg, lo_fall_next; // Low half, falling recapture.
  logic [DATA_W-1:0] hi_rise_reg, hi_rise_next; // High half, rising recapture.
  logic              dml_f_reg,   dml_f_next;   // Low mask, falling recapture.
  logic              dmh_r_reg,   dmh_r_next;   // High mask, rising recapture.
  logic              oe_a_n_reg,  oe_a_n_next;  // Data enable, first flop.
  logic              oe_b_n_reg,  oe_b_n_next;  // Data enable, second flop.
  logic              oe_h_n_reg,  oe_h_n_next;  // Data enable, high recapture.
  logic              sa_n_reg,    sa_n_next;    // Strobe enable, first flop.
  logic              sb_n_reg,    sb_n_next;    // Strobe enable, second flop.

  // Loads and recaptures on the generated clock edges.
  always_comb begin
    word_next    = word_reg;
    lo_fall_next = lo_fall_reg;
    hi_rise_next = hi_rise_reg;
    dml_f_next   = dml_f_reg;
    dmh_r_next   = dmh_r_reg;
    oe_a_n_next  = oe_a_n_reg;
    oe_b_n_next  = oe_b_n_reg;
    oe_h_n_next  = oe_h_n_reg;
    sa_n_next    = sa_n_reg;
    sb_n_next    = sb_n_reg;
    if (wr_rise) begin
      word_next    = wr_word_in;
      hi_rise_next = word_reg.hi;
      dmh_r_next   = word_reg.dm_hi;
      oe_a_n_next  = !wr_en_in;
      oe_h_n_next  = oe_a_n_reg;
    end
    if (wr_fall) begin
      lo_fall_next = word_reg.lo;
      dml_f_next   = word_reg.dm_lo;
      oe_b_n_next  = oe_a_n_reg;
    end
    if (sys_rise) begin
      sa_n_next = !wr_en_in;
    end
    if (sys_fall) begin
      sb_n_next = sa_n_reg;
    end
  end

  // Write path registers.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      word_reg    <= '0;
      lo_fall_reg <= DATA_RST;
      hi_rise_reg <= DATA_RST;
      dml_f_reg   <= 1'b0;
      dmh_r_reg   <= 1'b0;
      oe_a_n_reg  <= OE_N_RST;
      oe_b_n_reg  <= OE_N_RST;
      oe_h_n_reg  <= OE_N_RST;
      sa_n_reg    <= OE_N_RST;
      sb_n_reg    <= OE_N_RST;
    end else begin
      word_reg    <= word_next;
      lo_fall_reg <= lo_fall_next;
      hi_rise_reg <= hi_rise_next;
      dml_f_reg   <= dml_f_next;
      dmh_r_reg   <= dmh_r_next;
      oe_a_n_reg  <= oe_a_n_next;
      oe_b_n_reg  <= oe_b_n_next;
      oe_h_n_reg  <= oe_h_n_next;
      sa_n_reg    <= sa_n_next;
      sb_n_reg    <= sb_n_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin multiplexers and output flops.
  ////////////////////////////////////////////////////////////////////////////

  logic              wr_hi_ph;    // Write clock high in the next cycle.
  logic              sys_hi_ph;   // System clock high in the next cycle.
  logic [DATA_W-1:0] dq_o_next;   // Next data pin value.
  logic              dm_o_next;   // Next mask pin value.
  logic              dq_oe_next;  // Next data enable.
  logic              dqs_oe_next; // Next strobe enable.

  // The clock level itself picks the half, so the pin moves twice per
  // period.  Either strobe enable flop holding off keeps the strobe
  // released, which stretches its high impedance by half a period.  The
  // data enable follows its own half, so the last high beat of a burst
  // still leaves with the pins driven.
  always_comb begin
    wr_hi_ph    = (phase_next == PH_Q1) || (phase_next == PH_Q2);
    sys_hi_ph   = (phase_next == PH_Q0) || (phase_next == PH_Q1);
    dq_o_next   = wr_hi_ph ? hi_rise_next : lo_fall_next;
    dm_o_next   = wr_hi_ph ? dmh_r_next : dml_f_next;
    dq_oe_next  = wr_hi_ph ? !oe_h_n_next : !oe_b_n_next;
    dqs_oe_next = !(sa_n_next || sb_n_next);
  end

  // Every output leaves from a flop.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      dq_out        <= DATA_RST;
      dm_out        <= 1'b0;
      dq_oe_out     <= 1'b0;
      dqs_out       <= 1'b0;
      dqs_oe_out    <= 1'b0;
      mem_clk_out   <= 1'b0;
      wr_clk_out    <= 1'b0;
      core_tick_out <= 1'b0;
    end else begin
      dq_out        <= dq_o_next;
      dm_out        <= dm_o_next;
      dq_oe_out     <= dq_oe_next;
      dqs_out       <= sys_hi_ph;
      dqs_oe_out    <= dqs_oe_next;
      mem_clk_out   <= sys_hi_ph;
      wr_clk_out    <= wr_hi_ph;
      core_tick_out <= sys_rise;
    end
  end

  // Read outputs come straight from the sync registers and the valid register.
  always_comb begin
    rd_hi_out    = sync_reg.hi;
    rd_lo_out    = sync_reg.lo;
    rd_valid_out = rd_valid_reg;
  end

endmodule

// [shared/ddr_io_pkg.sv]
// Constants and types shared by the DDR input and output register datapath.
// How it works
// - Three capture flops per data pin.
// - First flop samples on capture rising edge.
// - Second flop samples on capture falling edge.
// - Third flop aligns halves before handoff.
// - Aligned halves pass through pair of sync registers.
// - Capture uses capture clock input pin, no strobe.
// - High and low streams load same edge.
// - Low stream flop recaptured on falling edge.
// - High stream flop recaptured on rising edge.
// - Clock selects between halves, double rate pin.
// - Output enable uses same two-flop structure.
// - Strobe stays high impedance extra half cycle.
// - Enable active low, inverter before first flop.
// - Generator gives system, write, core clocks; capture clock is an input.
// - System clock drives strobe, command, address timing.
// - Write clock lags system clock by quarter.
// - Capture phase is adjustable for margin tracking.
// - Mask outputs timed by write clock.
package ddr_io_pkg;

  // Width of one data group on the pins.
  localparam int unsigned DATA_W = 8;

  // System clock period and memory clock period in nanoseconds.
  localparam int unsigned SYS_PERIOD_NS = 100;
  localparam int unsigned MEM_PERIOD_NS = 800;

  // System cycles per quarter of the memory clock period, at least one.
  localparam int unsigned QTR_CYC_RAW = MEM_PERIOD_NS / (4 * SYS_PERIOD_NS);
  localparam int unsigned QTR_CYC = (QTR_CYC_RAW < 1) ? 1 : QTR_CYC_RAW;

  // Width of the quarter counter and of the capture delay setting.
  localparam int unsigned QCNT_W = 4;
  localparam int unsigned DLY_W  = 3;

  // Reset values of data and of active-low enables.
  localparam logic [DATA_W-1:0] DATA_RST = '0;
  localparam logic              OE_N_RST = 1'b1;

  // Quarter phases of the memory clock.  System clock is high in Q0 and
  // Q1, the write clock (a quarter later) is high in Q1 and Q2.
  typedef enum logic [1:0] {
    PH_Q0 = 2'b00,
    PH_Q1 = 2'b01,
    PH_Q2 = 2'b10,
    PH_Q3 = 2'b11
  } phase_t;

  // One single-rate write word: both data halves and both mask halves.
  typedef struct packed {
    logic [DATA_W-1:0] hi;
    logic [DATA_W-1:0] lo;
    logic              dm_hi;
    logic              dm_lo;
  } wr_word_t;

  // One captured double-rate read pair.
  typedef struct packed {
    logic [DATA_W-1:0] hi;
    logic [DATA_W-1:0] lo;
  } rd_pair_t;

endpackage

// [sim/ddr_mem_model.sv]
// Behavioural memory read side: drives the capture clock and read data.
`timescale 1ns/1ps
module ddr_mem_model
  import ddr_io_pkg::*;
(
  output logic              cap_clk_out,  // Capture clock, still between.
  output logic [DATA_W-1:0] dq_out        // Read data toward the datapath.
);
  // The clock rests low between frames; it never runs free.
  initial begin
    cap_clk_out = 1'b0;
    dq_out      = '0;
  end

  //////////////////////////////////////////////////////////////////////
  // One 800 ns beat pair: each half changes just before its edge and then
  // holds, leaving room for two sync stages plus the trim.  The first pair
  // of a frame is offset so edges never line up with clk.
  task automatic send_pair(input logic              first,
                           input logic [DATA_W-1:0] hi,
                           input logic [DATA_W-1:0] lo);
    if (first) #37;
    dq_out = hi;
    #10 cap_clk_out = 1'b1;
    #390 dq_out = lo;
    #10 cap_clk_out = 1'b0;
    // Hold time is over, so the pin shows a changed value, not the old.
    #390 dq_out = ~lo;
  endtask

  // Write side: a beat with its mask high leaves the stored byte alone.
  function automatic logic [DATA_W-1:0] store_beat(
      input logic [DATA_W-1:0] prev,
      input logic [DATA_W-1:0] beat,
      input logic              mask);
    return mask ? prev : beat;
  endfunction
endmodule

// [sim/ddr_io_datapath_monitor.sv]
// Concurrent checks on the DDR datapath clock, write and read outputs.
`timescale 1ns/1ps
module ddr_io_datapath_monitor
  import ddr_io_pkg::*;
#(
  parameter int unsigned QTR_CYCLES = QTR_CYC  // System cycles per quarter.
) (
  input wire logic              clk_sys_in,    // System clock.
  input wire logic              rst_in,        // Synchronous reset.
  input wire logic [DATA_W-1:0] rd_hi_out,     // Read high half.
  input wire logic [DATA_W-1:0] rd_lo_out,     // Read low half.
  input wire logic              rd_valid_out,  // Read pair pulse.
  input wire logic [DATA_W-1:0] dq_out,        // Data drive value.
  input wire logic              dq_oe_out,     // Data enable.
  input wire logic              dm_out,        // Mask drive value.
  input wire logic              dqs_out,       // Strobe drive value.
  input wire logic              dqs_oe_out,    // Strobe enable.
  input wire logic              mem_clk_out,   // Memory system clock.
  input wire logic              wr_clk_out,    // Write clock.
  input wire logic              core_tick_out  // Core rate pulse.
);
  localparam int QTR  = QTR_CYCLES;      // Quarter of the memory period.
  localparam int HALF = 2 * QTR_CYCLES;  // Half of the memory period.

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  //////////////////////////////////////////////////////////////////////
  a_mem_clk_period: assert property ($rose(mem_clk_out) |->
    ##HALF $fell(mem_clk_out) ##HALF $rose(mem_clk_out))
    else $error("memory clock period is wrong");
  a_wr_clk_lag: assert property ($rose(mem_clk_out) |->
    ##QTR $rose(wr_clk_out)) else $error("write clock lag is wrong");
  a_core_tick: assert property ($rose(mem_clk_out) |->
    core_tick_out ##1 !core_tick_out) else $error("core tick misplaced");
  a_strobe_level: assert property (dqs_oe_out |->
    dqs_out == mem_clk_out) else $error("strobe not on system clock");
  a_strobe_preamble: assert property ($rose(dqs_oe_out) |->
    $fell(mem_clk_out)) else $error("strobe enable without preamble");
  a_data_oe_half: assert property ($rose(dq_oe_out) |->
    $fell(wr_clk_out)) else $error("data enable not on write fall");
  a_dq_on_wr_edge: assert property ($changed(dq_out) |->
    $changed(wr_clk_out)) else $error("data moved off write edge");
  a_dm_on_wr_edge: assert property ($changed(dm_out) |->
    $changed(wr_clk_out)) else $error("mask moved off write edge");
  a_rd_pair_hold: assert property (!rd_valid_out |->
    $stable(rd_hi_out) && $stable(rd_lo_out))
    else $error("read pair changed without valid");
  a_valid_pulse: assert property (rd_valid_out |=> !rd_valid_out)
    else $error("read valid longer than one cycle");

  // Main scenarios reached.
  c_read_pair: cover property (rd_valid_out);
  c_data_enable: cover property ($rose(dq_oe_out));
  c_strobe_enable: cover property ($rose(dqs_oe_out));
endmodule

bind ddr_io_datapath ddr_io_datapath_monitor #(.QTR_CYCLES(QTR_CYCLES))
  u_mon (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
         .rd_hi_out(rd_hi_out), .rd_lo_out(rd_lo_out),
         .rd_valid_out(rd_valid_out), .dq_out(dq_out),
         .dq_oe_out(dq_oe_out), .dm_out(dm_out), .dqs_out(dqs_out),
         .dqs_oe_out(dqs_oe_out), .mem_clk_out(mem_clk_out),
         .wr_clk_out(wr_clk_out), .core_tick_out(core_tick_out));

// [sim/ddr_io_datapath_bench.sv]
// Self-checking bench for the DDR datapath read and write paths.
`timescale 1ns/1ps
module ddr_io_datapath_bench
  import ddr_io_pkg::*;
;
  // Expected write half: which write clock half, then data and mask.
  typedef struct packed {
    logic              half;
    logic [DATA_W*2:0] val;
  } wnote_t;

  logic              clk_sys = 1'b0;  // System clock.
  logic              rst = 1'b1;      // Reset, held from time zero.
  logic [DLY_W-1:0]  cap_delay = '0;  // Capture trim.
  wr_word_t          wr_word = '0;    // Write word toward the design.
  logic              wr_en = 1'b0;    // Write enable.
  logic              cap_clk, rd_valid, dq_oe, dm, dqs, dqs_oe;
  logic              mem_clk, wr_clk, tick, wr_clk_d;
  logic [DATA_W-1:0] dq_rd, rd_hi, rd_lo, dq_wr;
  logic [DATA_W*2:0] rexp;            // Expected read pair.
  logic [DATA_W*2-1:0] rd_q[$];       // Read pairs still to appear.
  wnote_t            wr_q[$];         // Write halves still to appear.
  wnote_t            note;            // Write half under comparison.
  logic [DATA_W-1:0] stored = '0;     // Memory byte after masked beats.
  logic [DATA_W-1:0] stored_exp = '0; // Byte expected in memory.
  int                seed = 67;
  int                since = 0;       // Cycles since a write clock edge.
  int                mismatches = 0;
  int                checks_done = 0;

  always #50 clk_sys = ~clk_sys;

  ddr_mem_model u_mem (.cap_clk_out(cap_clk), .dq_out(dq_rd));

  ddr_io_datapath u_dut (
    .clk_sys_in(clk_sys), .rst_in(rst), .dq_in(dq_rd),
    .cap_clk_in(cap_clk), .cap_delay_in(cap_delay),
    .wr_word_in(wr_word), .wr_en_in(wr_en), .rd_hi_out(rd_hi),
    .rd_lo_out(rd_lo), .rd_valid_out(rd_valid), .dq_out(dq_wr),
    .dq_oe_out(dq_oe), .dm_out(dm), .dqs_out(dqs), .dqs_oe_out(dqs_oe),
    .mem_clk_out(mem_clk), .wr_clk_out(wr_clk), .core_tick_out(tick));

  //////////////////////////////////////////////////////////////////////
  task automatic check(input logic [DATA_W*2:0] got,
                       input logic [DATA_W*2:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
  endtask

  // Watcher: outputs are read before this edge's updates land.  Write
  // halves are taken mid-half while the data pins are driven, so a
  // one-cycle skew does not matter.
  always @(posedge clk_sys) begin
    wr_clk_d <= wr_clk;
    since <= (wr_clk !== wr_clk_d) ? 1 : since + 1;
    if (since == 2 && dq_oe === 1'b1 && wr_q.size() > 0 &&
        wr_q[0].half === wr_clk) begin
      note = wr_q.pop_front();
      check({dq_wr, dm}, note.val);
      stored = u_mem.store_beat(stored, dq_wr, dm);
      if (!note.val[0]) stored_exp = note.val[DATA_W:1];
      check(17'(stored), 17'(stored_exp));
    end
    if (rd_valid === 1'b1) begin
      // A pair nobody asked for sets the top bit, so it cannot match.
      rexp = (rd_q.size() > 0) ? {1'b0, rd_q.pop_front()} : {1'b1, 16'h0};
      check({1'b0, rd_hi, rd_lo}, rexp);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Three pairs, then a flush pair whose rise releases the last one; its
  // own pending half is dropped by the next reset.
  task automatic read_frame(input logic [DLY_W-1:0] dly);
    logic [DATA_W-1:0] hi, lo;
    do_reset();
    cap_delay <= dly;
    for (int i = 0; i < 4; i++) begin
      hi = DATA_W'($random(seed));
      lo = DATA_W'($random(seed));
      if (i < 3) rd_q.push_back({hi, lo});
      u_mem.send_pair(i == 0, hi, lo);
    end
    repeat (20) @(posedge clk_sys);
    check(17'(rd_q.size()), '0);
    $display("read frame with trim %0d done", dly);
  endtask

  // Back-to-back words, one per memory period, starting in Q0.
  task automatic write_burst(input int n);
    wr_word_t w;
    @(posedge clk_sys iff tick === 1'b1);
    for (int i = 0; i < n; i++) begin
      if (i == 2) check(17'({dq_oe, dqs_oe}), 17'h3);
      w = wr_word_t'($random(seed));
      wr_en <= 1'b1;
      wr_word <= w;
      wr_q.push_back('{half: 1'b0, val: 17'({w.lo, w.dm_lo})});
      wr_q.push_back('{half: 1'b1, val: 17'({w.hi, w.dm_hi})});
      repeat (8) @(posedge clk_sys);
    end
    wr_en <= 1'b0;
    repeat (24) @(posedge clk_sys);
    check(17'(wr_q.size()), '0);
    check(17'({dq_oe, dqs_oe}), '0);
    $display("write burst of %0d done", n);
  endtask

  // Cuts a hang short; the tests need about 27 us.
  initial begin
    #1_000_000;
    mismatches++;
    give_verdict();
  end

  initial begin
    for (int d = 0; d < 3; d++) read_frame(DLY_W'(d));
    do_reset();
    write_burst(1);
    write_burst(4);
    give_verdict();
  end
endmodule
